// File: pkg/emh_pkg.sv
// Package with constants and types for the nonvolatile module host controller.
package emh_pkg;

   // ****************************************************************
   // Geometry of the module.
   // ****************************************************************
   localparam int ADDR_W          = 19;
   localparam int DATA_W          = 8;
   localparam int PLANE_W         = 17;
   localparam int PLANE_CNT       = 4;
   localparam int PAGE_BYTES      = 256;
   localparam int PAGE_IDX_W      = 8;
   localparam int TOP_BIT         = 18;

   // Page modes selecting the address permutation.
   localparam logic [1:0] PMODE_256  = 2'h0;
   localparam logic [1:0] PMODE_512  = 2'h1;
   localparam logic [1:0] PMODE_1024 = 2'h2;

   // ****************************************************************
   // Timing, in ns, us and ms and in 10 ns clock cycles.
   // ****************************************************************
   localparam int CLK_NS          = 10;
   localparam int T_RC_NS         = 300;
   localparam int T_OE_NS         = 100;
   localparam int T_WP_NS         = 125;
   localparam int T_WPH_NS        = 100;
   localparam int T_DH_NS         = 35;
   localparam int T_AH_NS         = 125;
   localparam int T_DW_US         = 10;
   localparam int T_WC_MS         = 10;
   localparam int T_BLC_US_MAX    = 100;
   localparam int RD_CYC   = (T_RC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int WPH_CYC  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC = (T_AH_NS + CLK_NS - 1) / CLK_NS;
   localparam int NWD_CYC  = (T_DW_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int WC_CYC   = T_WC_MS * 1000000 / CLK_NS;
   localparam int CNT_W    = 24;

   // Host bus operation codes.
   localparam logic [1:0] OP_READ  = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;

   // Controller states, one-hot.
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_READ  = 5'h02,
      ST_WLOW  = 5'h04,
      ST_WHIGH = 5'h08,
      ST_GAP   = 5'h10
   } emh_state_t;

endpackage : emh_pkg

// File: pkg/emh_busy_if.sv
// Interface that carries plane busy tracking between controller and tracker.
`timescale 1ns/1ps
`default_nettype none
interface emh_busy_if;
   import emh_pkg::*;
   logic                 start;
   logic [1:0]           plane;
   logic [1:0]           query;
   logic                 busy;
   logic [PLANE_CNT-1:0] busy_map;

   modport ctl (output start, output plane, output query, input busy, input busy_map);
   modport trk (input start, input plane, input query, output busy, output busy_map);
endinterface : emh_busy_if
`default_nettype wire

// File: rtl/emh_plane_busy.sv
// Per-plane write cycle timers of the nonvolatile module host controller.
`timescale 1ns/1ps
`default_nettype none
module emh_plane_busy
   import emh_pkg::*;
#(
   parameter int WC_CYCLES = WC_CYC
) (
   input  wire logic clk,
   input  wire logic arst_n,
   emh_busy_if.trk   bi
);

   // ****************************************************************
   // One countdown per plane.
   // ****************************************************************
   logic [CNT_W-1:0] cnt_r   [PLANE_CNT];
   logic [CNT_W-1:0] cnt_nxt [PLANE_CNT];

   genvar g;
   generate
      for (g = 0; g < PLANE_CNT; g++) begin : g_pl
         // A new page load on this plane reloads its full write cycle time.
         always_comb begin
            cnt_nxt[g] = cnt_r[g];
            if (bi.start && bi.plane == 2'(g)) begin
               cnt_nxt[g] = CNT_W'(WC_CYCLES);
            end else if (cnt_r[g] != '0) begin
               cnt_nxt[g] = cnt_r[g] - 1'b1;
            end
         end
         // Countdown register.
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) cnt_r[g] <= '0;
            else         cnt_r[g] <= cnt_nxt[g];
         end
         assign bi.busy_map[g] = (cnt_r[g] != '0);
      end
   endgenerate

   // Busy state of the plane being asked about.
   assign bi.busy = bi.busy_map[bi.query];

endmodule : emh_plane_busy
`default_nettype wire

// File: rtl/emh_host_ctl.sv
// Host controller that drives a four-plane byte-wide nonvolatile module.
// Notes on behaviour
// - Read is select low, drive low, write high; write is select low, drive high.
// - At least 10 us pass between the end of one page write and the next write.
// - Optional lock keeps the write strobe high when the top address bit is set.
// - Straight wiring gives four planes with 256-byte sequential pages.
// - Permuted address lines give 512-byte or 1024-byte sequential pages.
// - A page write loads one to 256 bytes inside one write window.
`timescale 1ns/1ps
`default_nettype none
module emh_host_ctl
   import emh_pkg::*;
#(
   parameter int WC_CYCLES  = WC_CYC,
   parameter int NWD_CYCLES = NWD_CYC
) (
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              req_valid,
   input  wire logic [1:0]        req_op,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic              req_last,
   input  wire logic [1:0]        page_mode,
   input  wire logic              lock_upper,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic                   rsp_err,
   output logic [PLANE_CNT-1:0]   plane_busy,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_cs_n,
   output logic                   mem_oe_n,
   output logic                   mem_we_n,
   output logic [DATA_W-1:0]      mem_dq_o,
   output logic                   mem_dq_oe_n,
   input  wire logic [DATA_W-1:0] mem_dq_i
);

   // ****************************************************************
   // Address translation.
   // ****************************************************************

   // Maps a system address to module address lines for a page mode.
   function automatic logic [ADDR_W-1:0] map_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [1:0]        m);
      logic [ADDR_W-1:0] r;
      r = a;
      if (m == PMODE_512) begin
         r = {a[18], a[8], a[17:9], a[7:0]};
      end else if (m == PMODE_1024) begin
         r = {a[9], a[8], a[18:10], a[7:0]};
      end
      return r;
   endfunction : map_addr

   // Page identity: module address bits above the page byte index.
   function automatic logic [ADDR_W-PAGE_IDX_W-1:0] page_of(input logic [ADDR_W-1:0] ma);
      return ma[ADDR_W-1:PAGE_IDX_W];
   endfunction : page_of

   logic [ADDR_W-1:0] req_maddr;
   logic [1:0]        req_plane;
   assign req_maddr = map_addr(req_addr, page_mode);
   assign req_plane = req_maddr[ADDR_W-1:PLANE_W];

   // ****************************************************************
   // Plane busy tracking.
   // ****************************************************************
   emh_busy_if bi ();
   emh_plane_busy #(.WC_CYCLES(WC_CYCLES)) u_busy (
      .clk    (clk),
      .arst_n (arst_n),
      .bi     (bi)
   );

   // ****************************************************************
   // State and registers.
   // ****************************************************************
   emh_state_t                    st_r, st_nxt;
   logic [CNT_W-1:0]              cnt_r, cnt_nxt;
   logic [CNT_W-1:0]              gap_r, gap_nxt;
   logic                          win_r, win_nxt;
   logic [ADDR_W-PAGE_IDX_W-1:0]  wpage_r, wpage_nxt;
   logic [1:0]                    wplane_r, wplane_nxt;
   logic [PAGE_IDX_W:0]           nbyte_r, nbyte_nxt;
   logic                          last_r, last_nxt;
   logic                          ready_r, ready_nxt;
   logic                          rv_r, rv_nxt;
   logic [DATA_W-1:0]             rd_r, rd_nxt;
   logic                          err_r, err_nxt;
   logic [ADDR_W-1:0]             addr_r, addr_nxt;
   logic                          cs_r, cs_nxt, oe_r, oe_nxt, we_r, we_nxt;
   logic [DATA_W-1:0]             dq_r, dq_nxt;
   logic                          dqoe_r, dqoe_nxt;
   logic                          start_nxt;
   logic [PLANE_CNT-1:0]          pb_r;

   assign bi.query = req_plane;
   assign bi.plane = wplane_r;

   // Next-state logic of the strobe sequencer.
   always_comb begin
      st_nxt     = st_r;
      cnt_nxt    = cnt_r;
      gap_nxt    = (gap_r != '0) ? gap_r - 1'b1 : gap_r;
      win_nxt    = win_r;
      wpage_nxt  = wpage_r;
      wplane_nxt = wplane_r;
      nbyte_nxt  = nbyte_r;
      last_nxt   = last_r;
      ready_nxt  = 1'b0;
      rv_nxt     = 1'b0;
      rd_nxt     = rd_r;
      err_nxt    = 1'b0;
      addr_nxt   = addr_r;
      cs_nxt     = 1'b1;
      oe_nxt     = 1'b1;
      we_nxt     = 1'b1;
      dq_nxt     = dq_r;
      dqoe_nxt   = 1'b1;
      start_nxt  = 1'b0;
      case (st_r)
         ST_IDLE: begin
            ready_nxt = 1'b1;
            if (req_valid && ready_r) begin
               ready_nxt = 1'b0;
               addr_nxt  = req_maddr;
               if (req_op == OP_READ) begin
                  if (win_r && req_plane == wplane_r) begin
                     err_nxt = 1'b1;
                     rv_nxt  = 1'b1;
                     ready_nxt = 1'b1;
                  end else begin
                     st_nxt  = ST_READ;
                     cnt_nxt = CNT_W'(RD_CYC);
                     cs_nxt  = 1'b0;
                     oe_nxt  = 1'b0;
                  end
               end else if ((lock_upper && req_maddr[TOP_BIT])
                            || bi.busy
                            || (gap_r != '0)
                            || (win_r && (page_of(req_maddr) != wpage_r
                                          || nbyte_r == 9'(PAGE_BYTES)))) begin
                  err_nxt   = 1'b1;
                  rv_nxt    = 1'b1;
                  ready_nxt = 1'b1;
               end else begin
                  st_nxt     = ST_WLOW;
                  cnt_nxt    = CNT_W'(WP_CYC);
                  win_nxt    = 1'b1;
                  wpage_nxt  = page_of(req_maddr);
                  wplane_nxt = req_plane;
                  nbyte_nxt  = win_r ? nbyte_r + 1'b1 : 9'h001;
                  last_nxt   = req_last;
                  dq_nxt     = req_wdata;
                  dqoe_nxt   = 1'b0;
                  cs_nxt     = 1'b0;
                  we_nxt     = 1'b0;
               end
            end
         end
         ST_READ: begin
            cs_nxt  = 1'b0;
            oe_nxt  = 1'b0;
            cnt_nxt = cnt_r - 1'b1;
            if (cnt_r == CNT_W'(1)) begin
               rd_nxt    = mem_dq_i;
               rv_nxt    = 1'b1;
               cs_nxt    = 1'b1;
               oe_nxt    = 1'b1;
               st_nxt    = ST_IDLE;
               ready_nxt = 1'b1;
            end
         end
         ST_WLOW: begin
            cs_nxt   = 1'b0;
            we_nxt   = 1'b0;
            dqoe_nxt = 1'b0;
            cnt_nxt  = cnt_r - 1'b1;
            if (cnt_r == CNT_W'(1)) begin
               we_nxt  = 1'b1;
               st_nxt  = ST_WHIGH;
               cnt_nxt = CNT_W'(HOLD_CYC);
            end
         end
         ST_WHIGH: begin
            dqoe_nxt = 1'b0;
            cnt_nxt  = cnt_r - 1'b1;
            if (cnt_r == CNT_W'(1)) begin
               dqoe_nxt = 1'b1;
               rv_nxt   = 1'b1;
               if (last_r || nbyte_r == 9'(PAGE_BYTES)) begin
                  win_nxt   = 1'b0;
                  start_nxt = 1'b1;
                  gap_nxt   = CNT_W'(NWD_CYCLES);
                  st_nxt    = ST_GAP;
               end else begin
                  st_nxt    = ST_IDLE;
                  ready_nxt = 1'b1;
               end
            end
         end
         ST_GAP: begin
            st_nxt    = ST_IDLE;
            ready_nxt = 1'b1;
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   assign bi.start = start_nxt && (st_r == ST_WHIGH);

   // Registers of the sequencer and every pin driver.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r     <= ST_IDLE;
         cnt_r    <= '0;
         gap_r    <= '0;
         win_r    <= 1'b0;
         wpage_r  <= '0;
         wplane_r <= 2'h0;
         nbyte_r  <= '0;
         last_r   <= 1'b0;
         ready_r  <= 1'b0;
         rv_r     <= 1'b0;
         rd_r     <= 8'h00;
         err_r    <= 1'b0;
         addr_r   <= '0;
         cs_r     <= 1'b1;
         oe_r     <= 1'b1;
         we_r     <= 1'b1;
         dq_r     <= 8'h00;
         dqoe_r   <= 1'b1;
         pb_r     <= 4'h0;
      end else begin
         st_r     <= st_nxt;
         cnt_r    <= cnt_nxt;
         gap_r    <= gap_nxt;
         win_r    <= win_nxt;
         wpage_r  <= wpage_nxt;
         wplane_r <= wplane_nxt;
         nbyte_r  <= nbyte_nxt;
         last_r   <= last_nxt;
         ready_r  <= ready_nxt;
         rv_r     <= rv_nxt;
         rd_r     <= rd_nxt;
         err_r    <= err_nxt;
         addr_r   <= addr_nxt;
         cs_r     <= cs_nxt;
         oe_r     <= oe_nxt;
         we_r     <= we_nxt;
         dq_r     <= dq_nxt;
         dqoe_r   <= dqoe_nxt;
         pb_r     <= bi.busy_map;
      end
   end

   // Outputs straight from flip-flops.
   assign req_ready   = ready_r;
   assign rsp_valid   = rv_r;
   assign rsp_rdata   = rd_r;
   assign rsp_err     = err_r;
   assign plane_busy  = pb_r;
   assign mem_addr    = addr_r;
   assign mem_cs_n    = cs_r;
   assign mem_oe_n    = oe_r;
   assign mem_we_n    = we_r;
   assign mem_dq_o    = dq_r;
   assign mem_dq_oe_n = dqoe_r;

endmodule : emh_host_ctl
`default_nettype wire

// File: verif/emh_host_ctl_assertions.sv
// Checker of the port behaviour of the nonvolatile module host controller.
`timescale 1ns/1ps
`default_nettype none
module emh_host_ctl_chk
   import emh_pkg::*;
#(
   parameter int WC_CYCLES  = WC_CYC,
   parameter int NWD_CYCLES = NWD_CYC
) (
   input wire logic                 clk,
   input wire logic                 arst_n,
   input wire logic                 req_valid,
   input wire logic [1:0]           req_op,
   input wire logic [ADDR_W-1:0]    req_addr,
   input wire logic [DATA_W-1:0]    req_wdata,
   input wire logic                 req_last,
   input wire logic [1:0]           page_mode,
   input wire logic                 lock_upper,
   input wire logic                 req_ready,
   input wire logic                 rsp_valid,
   input wire logic [DATA_W-1:0]    rsp_rdata,
   input wire logic                 rsp_err,
   input wire logic [PLANE_CNT-1:0] plane_busy,
   input wire logic [ADDR_W-1:0]    mem_addr,
   input wire logic                 mem_cs_n,
   input wire logic                 mem_oe_n,
   input wire logic                 mem_we_n,
   input wire logic [DATA_W-1:0]    mem_dq_o,
   input wire logic                 mem_dq_oe_n,
   input wire logic [DATA_W-1:0]    mem_dq_i
);
   logic [15:0]          gap_r;
   logic [15:0]          gap_nxt;
   logic [15:0]          bsy_r;
   logic [15:0]          bsy_nxt;
   logic [PLANE_CNT-1:0] pb_r;

   // ****************************************************************
   // Cycle counters since a plane timer started and while plane 0 is busy.
   // ****************************************************************
   always_comb begin
      gap_nxt = (|(plane_busy & ~pb_r)) ? 16'h0000 : gap_r + {15'h0000, gap_r != 16'hFFFF};
      bsy_nxt = plane_busy[0] ? bsy_r + 16'h0001 : 16'h0000;
   end

   // Registers the counters; the gap starts saturated so the first write is free.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         gap_r <= 16'hFFFF;
         bsy_r <= 16'h0000;
         pb_r  <= '0;
      end else begin
         gap_r <= gap_nxt;
         bsy_r <= bsy_nxt;
         pb_r  <= plane_busy;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_rd_take;
      req_valid && req_ready && req_op == OP_READ ##1 !mem_oe_n;
   endsequence
   sequence s_rd_hold;
      (!mem_oe_n && !mem_cs_n && mem_we_n)[*8];
   endsequence
   sequence s_wr_low;
      (!mem_we_n && !mem_cs_n && mem_oe_n)[*8];
   endsequence
   sequence s_wr_hold;
      (!mem_dq_oe_n && $stable(mem_addr))[*8];
   endsequence

   property p_rd_cycle;
      s_rd_take |-> s_rd_hold ##23 (rsp_valid && mem_oe_n);
   endproperty
   property p_wr_pulse;
      $fell(mem_we_n) |-> s_wr_low ##5 !mem_we_n ##1 mem_we_n;
   endproperty
   property p_wr_hold;
      $rose(mem_we_n) |-> s_wr_hold ##6 (mem_dq_oe_n && rsp_valid);
   endproperty
   property p_rd_nodrive;
      !mem_oe_n |-> mem_dq_oe_n && mem_we_n;
   endproperty
   property p_lock;
      lock_upper && !mem_we_n |-> !mem_addr[TOP_BIT];
   endproperty
   property p_busy_wr;
      $fell(mem_we_n) |-> !plane_busy[mem_addr[18:17]];
   endproperty
   property p_gap;
      $fell(mem_we_n) |-> gap_r >= NWD_CYCLES - 16;
   endproperty
   property p_busy_len;
      $fell(plane_busy[0]) |-> bsy_r >= WC_CYCLES - 2 && bsy_r <= WC_CYCLES + 2;
   endproperty
   property p_err_quiet;
      rsp_err |-> rsp_valid && mem_cs_n && $past(mem_cs_n);
   endproperty

   a_rd_cycle : assert property (p_rd_cycle)
      else $error("read strobes or answer out of place");
   a_wr_pulse : assert property (p_wr_pulse)
      else $error("write strobe width wrong");
   a_wr_hold : assert property (p_wr_hold)
      else $error("address or data not held after write strobe");
   a_rd_nodrive : assert property (p_rd_nodrive)
      else $error("data pins driven during a read");
   a_lock : assert property (p_lock)
      else $error("write strobe low on locked upper half");
   a_busy_wr : assert property (p_busy_wr)
      else $error("write to a busy plane");
   a_gap : assert property (p_gap)
      else $error("write too soon after previous write");
   a_busy_len : assert property (p_busy_len)
      else $error("plane busy time wrong");
   a_err_quiet : assert property (p_err_quiet)
      else $error("refused request touched the pins");
endmodule : emh_host_ctl_chk
`default_nettype wire

// File: verif/emh_mem_model.sv
// Behavioural model of the four-plane nonvolatile module.
`timescale 1ns/1ps
`default_nettype none
module emh_mem_model
   import emh_pkg::*;
#(
   parameter realtime           WC_NS  = 1000.0,
   parameter logic [DATA_W-1:0] ERASED = 8'hFF
) (
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire logic              cs_n,
   input  wire logic              oe_n,
   input  wire logic              we_n,
   input  wire logic [DATA_W-1:0] host_dq,
   input  wire logic              host_dq_oe_n,
   output logic      [DATA_W-1:0] dq
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   realtime           last_wr [PLANE_CNT] = '{default: -1.0e9};
   logic              wr_act;
   logic              drv;
   logic [DATA_W-1:0] val;
   logic [DATA_W-1:0] last_q;

   // A byte is stored when the write combination of strobes ends.
   always @(*) wr_act = !cs_n && !we_n && oe_n;
   always @(negedge wr_act) begin
      if ($realtime > 1.0) begin
         mem[mem_addr] = host_dq;
         last_wr[mem_addr[18:17]] = $realtime;
      end
   end

   // Read data comes from the array; a plane still programming answers inverted.
   always @(*) begin
      drv = !host_dq_oe_n || (!cs_n && !oe_n && we_n);
      val = host_dq;
      if (!cs_n && !oe_n && we_n) begin
         val = mem.exists(mem_addr) ? mem[mem_addr] : ERASED;
         if ($realtime - last_wr[mem_addr[18:17]] < WC_NS) val = ~val;
      end
   end

   // A released bus shows the inverse of the last driven value.
   always @(*) if (drv) last_q = val;
   assign dq = drv ? val : ~last_q;
endmodule : emh_mem_model
`default_nettype wire

// File: verif/test_eeprom_module_plane_access.sv
// Testbench of the nonvolatile module host controller.
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_module_plane_access
   import emh_pkg::*;
;
   localparam int WC  = 150;
   localparam int NWD = 60;
   typedef struct packed {
      logic [1:0] pm; logic lk; logic [11:0] dly; logic wr;
      logic [ADDR_W-1:0] a; logic [DATA_W-1:0] d; logic last; logic err;
   } emh_row_t;
   // Mode, lock, delay, write, address, data, last, refused.
   emh_row_t rows [21] = '{
      '{2'h0,1'h0,12'h000,1'h1,19'h20005,8'h3C,1'h1,1'h0}, '{2'h0,1'h0,12'h046,1'h1,19'h00100,8'h11,1'h0,1'h0},
      '{2'h0,1'h0,12'h000,1'h1,19'h00101,8'h22,1'h1,1'h0}, '{2'h0,1'h0,12'h000,1'h0,19'h20005,8'h3C,1'h0,1'h0},
      '{2'h0,1'h0,12'h000,1'h1,19'h00200,8'h00,1'h1,1'h1}, '{2'h0,1'h0,12'h000,1'h1,19'h40000,8'h00,1'h1,1'h1},
      '{2'h0,1'h0,12'h028,1'h1,19'h40000,8'h77,1'h1,1'h0}, '{2'h0,1'h0,12'h0C8,1'h0,19'h00101,8'h22,1'h0,1'h0},
      '{2'h0,1'h0,12'h000,1'h0,19'h00100,8'h11,1'h0,1'h0}, '{2'h0,1'h1,12'h064,1'h1,19'h60000,8'h00,1'h1,1'h1},
      '{2'h0,1'h1,12'h000,1'h1,19'h20001,8'h44,1'h1,1'h0}, '{2'h0,1'h0,12'h064,1'h1,19'h00300,8'h66,1'h0,1'h0},
      '{2'h0,1'h0,12'h000,1'h1,19'h00400,8'h00,1'h0,1'h1}, '{2'h0,1'h0,12'h000,1'h0,19'h00000,8'h00,1'h0,1'h1},
      '{2'h0,1'h0,12'h000,1'h1,19'h00301,8'h67,1'h1,1'h0}, '{2'h0,1'h0,12'h0C8,1'h1,19'h7FFFF,8'h99,1'h1,1'h0},
      '{2'h0,1'h1,12'h0C8,1'h0,19'h7FFFF,8'h99,1'h0,1'h0}, '{2'h1,1'h0,12'h000,1'h0,19'h00105,8'h3C,1'h0,1'h0},
      '{2'h2,1'h0,12'h064,1'h1,19'h00200,8'h55,1'h1,1'h0}, '{2'h0,1'h0,12'h0C8,1'h0,19'h40000,8'h55,1'h0,1'h0},
      '{2'h0,1'h0,12'h000,1'h0,19'h20001,8'h44,1'h0,1'h0}};
   logic                 clk, arst_n, req_valid, req_last, lock_upper, req_ready, rsp_valid;
   logic                 rsp_err, mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe_n, got_e;
   logic [1:0]           req_op, page_mode;
   logic [ADDR_W-1:0]    req_addr, mem_addr;
   logic [DATA_W-1:0]    req_wdata, rsp_rdata, mem_dq_o, mem_dq_i, got_d;
   logic [PLANE_CNT-1:0] plane_busy;
   logic [1:0]           exp_pl;
   int                   n_errors, check_count;

   emh_host_ctl #(.WC_CYCLES(WC), .NWD_CYCLES(NWD)) i_emh_host_ctl (
      .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
      .req_wdata(req_wdata), .req_last(req_last), .page_mode(page_mode), .lock_upper(lock_upper),
      .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
      .plane_busy(plane_busy), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n),
      .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o), .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_i(mem_dq_i));
   emh_mem_model i_emh_mem_model (.mem_addr(mem_addr), .cs_n(mem_cs_n), .oe_n(mem_oe_n),
      .we_n(mem_we_n), .host_dq(mem_dq_o), .host_dq_oe_n(mem_dq_oe_n), .dq(mem_dq_i));

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk

   // Holds one request until taken, then waits for its answer.
   task automatic do_req(input logic [1:0] op, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, input logic last);
      int i;
      req_op = op; req_addr = a; req_wdata = d; req_last = last; req_valid = 1'b1;
      for (i = 0; i < 2000 && req_ready !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      for (i = 0; i < 200 && rsp_valid !== 1'b1; i++) @(negedge clk);
      got_d = rsp_rdata;
      got_e = rsp_err;
      chk(rsp_valid, 32'h1, "answer");
      @(negedge clk);
   endtask : do_req

   task automatic wrap_up;
      $display("Errors %0d in %0d checks", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up

   // Clock and watchdog.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #400000;
      n_errors++;
      wrap_up;
   end

   // Main sequence: table rows, then reset in mid-write.
   initial begin
      arst_n = 1'b0; req_valid = 1'b0; req_op = OP_READ; req_addr = '0; req_wdata = '0;
      req_last = 1'b0; page_mode = PMODE_256; lock_upper = 1'b0; n_errors = 0; check_count = 0;
      repeat (12) @(negedge clk);
      chk({mem_cs_n, mem_oe_n, mem_we_n, mem_dq_oe_n, req_ready, plane_busy}, 32'h1E0, "reset");
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      foreach (rows[k]) begin
         page_mode = rows[k].pm;
         lock_upper = rows[k].lk;
         repeat (rows[k].dly) @(negedge clk);
         do_req({1'b0, rows[k].wr}, rows[k].a, rows[k].d, rows[k].last);
         chk(got_e, rows[k].err, "refusal");
         if (!rows[k].wr && !rows[k].err) chk(got_d, rows[k].d, "read data");
         // A closed page must mark the plane that its mapped address selects as busy.
         exp_pl = (rows[k].pm == PMODE_1024) ? {rows[k].a[9], rows[k].a[8]} :
                  (rows[k].pm == PMODE_512) ? {rows[k].a[18], rows[k].a[8]} : rows[k].a[18:17];
         if (rows[k].wr && rows[k].last && !rows[k].err)
            chk(plane_busy[exp_pl], 32'h1, "plane busy");
      end
      req_op = OP_WRITE; req_addr = 19'h00500; req_wdata = 8'hEE; req_last = 1'b1; req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      repeat (4) @(negedge clk);
      chk(mem_we_n, 32'h0, "write strobe");
      arst_n = 1'b0;
      #1;
      chk({mem_cs_n, mem_we_n, mem_dq_oe_n, req_ready}, 32'hE, "reset abort");
      repeat (12) @(negedge clk);
      arst_n = 1'b1;
      repeat (2) @(negedge clk);
      // The cut write may still be programming plane 0, so read back from plane 1.
      do_req(OP_READ, 19'h20001, 8'h00, 1'b0);
      chk(got_d, 32'h44, "read after reset");
      wrap_up;
   end
endmodule : test_eeprom_module_plane_access

bind emh_host_ctl emh_host_ctl_chk #(.WC_CYCLES(WC_CYCLES), .NWD_CYCLES(NWD_CYCLES)) i_emh_host_ctl_chk (
   .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
   .req_wdata(req_wdata), .req_last(req_last), .page_mode(page_mode), .lock_upper(lock_upper),
   .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err),
   .plane_busy(plane_busy), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_oe_n(mem_oe_n),
   .mem_we_n(mem_we_n), .mem_dq_o(mem_dq_o), .mem_dq_oe_n(mem_dq_oe_n), .mem_dq_i(mem_dq_i));
`default_nettype wire
